// >>> bench/flash_write_key_lock_tb.sv
// testbench: key sequence, flash gating, interrupts and bus scenarios
`timescale 1ns/1ps
module flash_write_key_lock_tb;
    import fwkl_pkg::*;
    // ==========================================================
    // signals and reference state
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, xwr_i = 1'b0;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'hF;
    logic [3:0] lat = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q, seed = 32'h7;
    logic [7:0] v;
    logic ack_o, err_o, fl_wr_o, fl_erase_o, fl_done_i, irq_o;
    int n_mismatch = 0, cmp_count = 0, m = 0, ctrl = 0, stat = 0, mask = 0;
    int cv[3] = '{1, 3, 2};
    int exp_op[$];
    always #2.5 clk_i = ~clk_i;
    fwkl_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .xwr_i(xwr_i), .fl_wr_o(fl_wr_o), .fl_erase_o(fl_erase_o),
        .fl_done_i(fl_done_i), .irq_o(irq_o));
    fwkl_flash_model flash (.clk_i(clk_i), .rst_i(rst_i), .wr_i(fl_wr_o),
        .erase_i(fl_erase_o), .lat_i(lat), .done_o(fl_done_i));
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(ack_o || err_o) && n < 50);
        q = dat_o;
        chk(32'(ack_o || err_o), 32'h1);
        chk(32'(err_o), 32'(!(a inside {FWKL_KEY_ADDR, FWKL_CTRL_ADDR, FWKL_IRQ_STAT_ADDR,
            FWKL_IRQ_MASK_ADDR})));
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        if (a == FWKL_CTRL_ADDR) ctrl = int'(d[1:0]);
        if (a == FWKL_IRQ_STAT_ADDR) stat = stat & ~int'(d[2:0]);
        if (a == FWKL_IRQ_MASK_ADDR) mask = int'(d[2:0]);
    endtask
    task automatic kw(input logic [7:0] k);
        q = rnd();
        wb(1'b1, FWKL_KEY_ADDR, {q[31:8], k});
        if (m == 0 && k == FWKL_KEY1) m = 1;
        else if (m == 1 && k == FWKL_KEY2) m = 2;
        else begin
            if (m != 3) stat |= 4;
            m = 3;
        end
    endtask
    task automatic rk();
        wb(1'b0, FWKL_KEY_ADDR, 32'h0);
        chk(q, 32'(m));
        wb(1'b0, FWKL_IRQ_STAT_ADDR, 32'h0);
        chk(q, 32'(stat));
        chk(32'(irq_o), 32'((stat & mask) != 0));
    endtask
    task automatic xw();
        int n;
        logic go;
        go = ctrl[0] && m == 2;
        exp_op.push_back(go ? (ctrl[1] ? 2 : 1) : 0);
        q = rnd();
        lat <= q[3:0];
        xwr_i <= 1'b1;
        @(posedge clk_i);
        xwr_i <= 1'b0;
        #1;
        chk({30'h0, fl_erase_o, fl_wr_o}, 32'(exp_op.pop_front()));
        n = 0;
        while (go && !fl_done_i && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        if (go) begin
            chk(32'(n < 40), 32'h1);
            m = 0;
            stat |= 1;
        end else if (ctrl[0]) begin
            stat |= (m == 3) ? 2 : 6;
            m = 3;
        end
    endtask
    task automatic rs();
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        m = 0;
        ctrl = 0;
        stat = 0;
        mask = 0;
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        rs();
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, (i == 3) ? FWKL_KEY_ADDR : 10'(4 * i), 32'h0);
            chk(q, 32'h0);
        end
        $display("test reset values done");
        wr(FWKL_IRQ_MASK_ADDR, 32'h7);
        // write, erase, then core write with program enable off leaves it armed
        for (int i = 0; i < 3; i++) begin
            wr(FWKL_CTRL_ADDR, 32'(cv[i]));
            kw(FWKL_KEY1);
            rk();
            kw(FWKL_KEY2);
            rk();
            xw();
            rk();
        end
        $display("test key and operations done");
        wr(FWKL_IRQ_MASK_ADDR, 32'h2);
        wr(FWKL_CTRL_ADDR, 32'h1);
        xw();
        xw();
        kw(FWKL_KEY1);
        rk();
        wr(FWKL_IRQ_STAT_ADDR, 32'h2);
        rk();
        wr(FWKL_IRQ_MASK_ADDR, 32'h7);
        rk();
        wr(FWKL_IRQ_STAT_ADDR, 32'h7);
        rk();
        $display("test refusal and interrupt done");
        for (int i = 0; i < 4; i++) begin
            rs();
            rk();
            wr(FWKL_CTRL_ADDR, 32'h1);
            q = rnd();
            v = q[7:0];
            if (v == FWKL_KEY1 || v == FWKL_KEY2) v ^= 8'h01;
            if (i[0]) kw(FWKL_KEY1);
            kw(v);
            rk();
            xw();
            rk();
        end
        $display("test broken sequences done");
        wb(1'b1, 10'h3FC, rnd());
        rk();
        $display("test unmapped access done");
        close_out();
    end
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule

// >>> bench/fwkl_flash_model.sv
// partner: flash controller that reports completion after a chosen latency
`timescale 1ns/1ps
module fwkl_flash_model (
    // strobes in
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic erase_i,
    input wire logic [3:0] lat_i,
    // completion out
    output logic done_o
);
    int cnt = 0;
    // latency 0 answers promptly, up to 15 stalls the block while it is busy
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cnt <= 0;
        end else if (wr_i || erase_i) begin
            cnt <= int'(lat_i) + 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            done_o <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// >>> bench/fwkl_top_properties.sv
// checker: bus answer, flash gating and reset properties of the top
`timescale 1ns/1ps
module fwkl_top_properties (
    // bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [fwkl_pkg::FWKL_ADDR_W-1:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    // flash and interrupt
    input wire logic xwr_i,
    input wire logic fl_wr_o,
    input wire logic fl_erase_o,
    input wire logic irq_o
);
    import fwkl_pkg::*;
    wire logic mapped = adr_i inside {FWKL_KEY_ADDR, FWKL_CTRL_ADDR, FWKL_IRQ_STAT_ADDR,
        FWKL_IRQ_MASK_ADDR};
    wire logic fl_any = fl_wr_o || fl_erase_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // properties
    property p_answer; cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    property p_ack_pulse; ack_o |=> !ack_o && !err_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_quiet; !ack_o |-> dat_o == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("read data without ack");
    property p_err_map; err_o |-> !$past(mapped); endproperty
    a_err_map: assert property (p_err_map) else $error("error on mapped address");
    property p_key_rd; ack_o && !$past(we_i) && $past(adr_i) == FWKL_KEY_ADDR |->
        dat_o[31:2] == 30'h0; endproperty
    a_key_rd: assert property (p_key_rd) else $error("key read upper bits");
    property p_cause; fl_any |-> $past(xwr_i); endproperty
    a_cause: assert property (p_cause) else $error("flash op without core write");
    property p_one_op; fl_any |-> !(fl_wr_o && fl_erase_o) ##1 !fl_any; endproperty
    a_one_op: assert property (p_one_op) else $error("flash op shape");
    property p_rst; $fell(rst_i) |-> !ack_o && !err_o && !irq_o && !fl_any; endproperty
    a_rst: assert property (p_rst) else $error("outputs busy after reset");
    c_write: cover property (fl_wr_o);
    c_erase: cover property (fl_erase_o);
    c_err: cover property (err_o);
endmodule
bind fwkl_top fwkl_top_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .xwr_i(xwr_i), .fl_wr_o(fl_wr_o), .fl_erase_o(fl_erase_o), .irq_o(irq_o));

// >>> verilog/fwkl_flash_gate.sv
// module: gates flash write/erase requests by the armed state
`timescale 1ns/1ps
module fwkl_flash_gate (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // enables and lock state
    input wire logic program_write_enable_i,
    input wire logic page_erase_enable_i,
    input wire logic armed_i,
    // core request
    input wire logic xwr_i,
    // to flash controller
    output logic fl_wr_o,
    output logic fl_erase_o,
    input wire logic fl_done_i,
    // to key logic
    output logic attempt_o,
    output logic refuse_o,
    output logic busy_o
);
    import fwkl_pkg::*;
    logic busy;
    wire req = xwr_i && program_write_enable_i && !busy;
    wire go = req && armed_i;
    wire is_erase = page_erase_enable_i;

    assign attempt_o = req && !armed_i;
    assign refuse_o = attempt_o;
    assign busy_o = busy;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            fl_wr_o <= 1'b0;
            fl_erase_o <= 1'b0;
        end else begin
            fl_wr_o <= go && !is_erase;
            fl_erase_o <= go && is_erase;
            if (go)
                busy <= 1'b1;
            else if (fl_done_i)
                busy <= 1'b0;
        end
    end
endmodule

// >>> verilog/fwkl_key_fsm.sv
// module: key sequence state machine guarding flash modification
`timescale 1ns/1ps
module fwkl_key_fsm (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // key events
    fwkl_key_if.fsm key,
    // flash operation events
    input wire logic op_attempt_i,
    input wire logic op_done_i,
    output logic armed_o
);
    import fwkl_pkg::*;
    fwkl_state_t state;
    fwkl_state_t next_state;
    wire key_ok1 = key.key_data == FWKL_KEY1;
    wire key_ok2 = key.key_data == FWKL_KEY2;

    // a key write and a flash attempt never coincide on a single-issue core;
    // if they did, the attempt is judged against the state before the write
    always_comb begin
        next_state = state;
        case (state)
            FWKL_LOCKED: begin
                if (op_attempt_i)
                    next_state = FWKL_PERM_LOCK;
                else if (key.key_wr)
                    next_state = key_ok1 ? FWKL_KEY1_SEEN : FWKL_PERM_LOCK;
            end
            FWKL_KEY1_SEEN: begin
                if (op_attempt_i)
                    next_state = FWKL_PERM_LOCK;
                else if (key.key_wr)
                    next_state = key_ok2 ? FWKL_ARMED : FWKL_PERM_LOCK;
            end
            FWKL_ARMED: begin
                if (op_done_i)
                    next_state = FWKL_LOCKED;
                else if (key.key_wr)
                    next_state = FWKL_PERM_LOCK;
            end
            FWKL_PERM_LOCK: next_state = FWKL_PERM_LOCK;
            default: next_state = FWKL_PERM_LOCK;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            state <= FWKL_LOCKED;
        else
            state <= next_state;
    end

    assign armed_o = state == FWKL_ARMED;
    assign key.state_code = state;
    assign key.lock_event = (state != FWKL_PERM_LOCK) && (next_state == FWKL_PERM_LOCK);
endmodule

// >>> verilog/fwkl_key_if.sv
// interface: key register events between bus slave and key state machine
`timescale 1ns/1ps
interface fwkl_key_if;
    logic key_wr;
    logic [7:0] key_data;
    logic [1:0] state_code;
    logic lock_event;
    modport slave (output key_wr, output key_data, input state_code, input lock_event);
    modport fsm (input key_wr, input key_data, output state_code, output lock_event);
endinterface

// >>> verilog/fwkl_pkg.sv
// package: register map, key codes, lock states and flash request commands
package fwkl_pkg;
    // ==========================================================
    // register map: the key register sits at word index 0xB6 of a byte-addressed bus
    localparam logic [7:0] FWKL_KEY_IDX = 8'hB6;
    localparam logic [9:0] FWKL_KEY_ADDR = {FWKL_KEY_IDX, 2'b00};
    localparam logic [9:0] FWKL_CTRL_ADDR = 10'h000;
    localparam logic [9:0] FWKL_IRQ_STAT_ADDR = 10'h004;
    localparam logic [9:0] FWKL_IRQ_MASK_ADDR = 10'h008;
    localparam int FWKL_ADDR_W = 10;
    localparam logic [7:0] FWKL_KEY_RESET = 8'h00;
    // ==========================================================
    // key codes
    localparam logic [7:0] FWKL_KEY1 = 8'hA5;
    localparam logic [7:0] FWKL_KEY2 = 8'hF1;
    // ==========================================================
    // control register fields
    localparam int FWKL_CTRL_PROG_WR_EN_BIT = 0;
    localparam int FWKL_CTRL_PAGE_ERASE_EN_BIT = 1;
    localparam logic [1:0] FWKL_CTRL_RESET = 2'h0;
    // ==========================================================
    // interrupt status fields
    localparam int FWKL_IRQ_W = 3;
    localparam int FWKL_EV_DONE = 0;
    localparam int FWKL_EV_REFUSE = 1;
    localparam int FWKL_EV_LOCK = 2;
    localparam logic [2:0] FWKL_IRQ_RESET = 3'h0;
    // ==========================================================
    // lock state codes as read back
    typedef enum logic [1:0] {
        FWKL_LOCKED = 2'b00,
        FWKL_KEY1_SEEN = 2'b01,
        FWKL_ARMED = 2'b10,
        FWKL_PERM_LOCK = 2'b11
    } fwkl_state_t;
    // ==========================================================
    // flash operation kinds
    typedef enum logic [1:0] {
        FWKL_OP_NONE,
        FWKL_OP_WRITE,
        FWKL_OP_ERASE
    } fwkl_op_t;
endpackage

// >>> verilog/fwkl_top.sv
// module: flash write key lock, top with Wishbone slave and interrupts
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module fwkl_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [fwkl_pkg::FWKL_ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // external-move write strobe from the core
    input wire logic xwr_i,
    // flash controller
    output logic fl_wr_o,
    output logic fl_erase_o,
    input wire logic fl_done_i,
    // interrupt
    output logic irq_o
);
    import fwkl_pkg::*;
    // ==========================================================
    // bus decode
    fwkl_key_if key ();
    logic [1:0] ctrl;
    logic [FWKL_IRQ_W-1:0] irq_stat;
    logic [FWKL_IRQ_W-1:0] irq_mask;
    logic armed;
    logic attempt;
    logic refuse;
    logic busy;

    wire req = cyc_i && stb_i && !ack_o && !err_o;
    wire hit_key = adr_i == FWKL_KEY_ADDR;
    wire hit_ctrl = adr_i == FWKL_CTRL_ADDR;
    wire hit_stat = adr_i == FWKL_IRQ_STAT_ADDR;
    wire hit_mask = adr_i == FWKL_IRQ_MASK_ADDR;
    wire hit_any = hit_key || hit_ctrl || hit_stat || hit_mask;
    wire wr_lane0 = req && we_i && hit_any && sel_i[0];
    // the key register is written through its low byte lane only
    assign key.key_wr = wr_lane0 && hit_key;
    assign key.key_data = dat_i[7:0];
    wire wr_ctrl = wr_lane0 && hit_ctrl;
    wire wr_stat = wr_lane0 && hit_stat;
    wire wr_mask = wr_lane0 && hit_mask;

    wire [31:0] rd_key = {30'h0, key.state_code};
    wire [31:0] rd_ctrl = {30'h0, ctrl};
    wire [31:0] rd_stat = {29'h0, irq_stat};
    wire [31:0] rd_mask = {29'h0, irq_mask};
    wire [31:0] rd_mux = hit_key ? rd_key : hit_ctrl ? rd_ctrl :
        hit_stat ? rd_stat : hit_mask ? rd_mask : 32'h0;

    // ==========================================================
    // bus response: one wait state, ack a cycle after strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req && hit_any;
            err_o <= req && !hit_any;
            dat_o <= (req && !we_i) ? rd_mux : 32'h0;
        end
    end

    // ==========================================================
    // enable bits
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ctrl <= FWKL_CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= dat_i[1:0];
    end

    // ==========================================================
    // interrupt status: set wins over write-one-to-clear
    wire [FWKL_IRQ_W-1:0] ev = {key.lock_event, refuse, fl_done_i && busy};
    wire [FWKL_IRQ_W-1:0] w1c = wr_stat ? dat_i[FWKL_IRQ_W-1:0] : {FWKL_IRQ_W{1'b0}};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= FWKL_IRQ_RESET;
            irq_mask <= FWKL_IRQ_RESET;
        end else begin
            irq_stat <= (irq_stat & ~w1c) | ev;
            if (wr_mask)
                irq_mask <= dat_i[FWKL_IRQ_W-1:0];
        end
    end
    assign irq_o = |(irq_stat & irq_mask);

    // ==========================================================
    // key state machine and flash request gate
    fwkl_key_fsm u_fsm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .key(key.fsm),
        .op_attempt_i(attempt),
        .op_done_i(fl_done_i && busy),
        .armed_o(armed)
    );

    fwkl_flash_gate u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .program_write_enable_i(ctrl[FWKL_CTRL_PROG_WR_EN_BIT]),
        .page_erase_enable_i(ctrl[FWKL_CTRL_PAGE_ERASE_EN_BIT]),
        .armed_i(armed),
        .xwr_i(xwr_i),
        .fl_wr_o(fl_wr_o),
        .fl_erase_o(fl_erase_o),
        .fl_done_i(fl_done_i),
        .attempt_o(attempt),
        .refuse_o(refuse),
        .busy_o(busy)
    );
endmodule
